// ==== core/option_word_decoder.sv ====
`timescale 1ns/1ps
`include "option_word_defs.svh"
// Notes on behaviour
// - mode bits 100 rc with pin io, 101 rc with clock out, rest reserved.
// - in any internal rc mode the second oscillator pin is plain io.
// - rc frequency 00 4 MHz, 01 1 MHz, 10 8 MHz, 11 455 kHz.
// - source bit 0 uses option field, 1 uses runtime register bits 7..6.
// - seven-bit trim from second word goes to the rc oscillator.
// - timer input bit 0 gives port pin, 1 gives timer external clock.
// - reset pin bit 1 gives external reset input, 0 port pin.
// - pulse width bit 1 accepts 8 clocks, 0 accepts 32 clocks.
// - noise filter enabled when bit is 0, bypassed when 1.
// - watchdog bit 1 turns watchdog on, 0 leaves it off.
// - protection off when all zero, on when upper two bits set.
// - brownout pair 00 off, 01 2.5V, 10 2.9V, 11 3.2V.
// - hold count 00 8, 01 4, 10 16, 11 32 cycles.
// - sub-clock select 0 gives 16 kHz, 1 gives 128 kHz.
// - five-bit trim from third word goes to the sub-oscillator.
// - regulator bit 1 powers rc regulator, 0 leaves it off.
// - option words cannot be read or written by the running program.
module option_word_decoder #(
  parameter int WORD_W = 13,
  parameter int LOAD_CYCLES = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WORD_W-1:0] option_config_first,
  input wire logic [WORD_W-1:0] option_config_second,
  input wire logic [WORD_W-1:0] option_config_third,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic core_rst_n,
  output option_word_pkg::clk_pin_ctrl_s clk_pin_ctrl,
  output option_word_pkg::sup_ctrl_s sup_ctrl
);
  import option_word_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (WORD_W != 13)
  begin : g_bad_width
    $error("option words must be 13 bits wide");
  end
  if (LOAD_CYCLES < 1 || LOAD_CYCLES > 15)
  begin : g_bad_load
    $error("load cycles must lie in 1..15");
  end

  // ----------------------------------------------------------------
  // capture sequence
  // ----------------------------------------------------------------
  load_state_e state_q;
  logic [3:0] load_cnt_q;
  logic [WORD_W-1:0] word0_q;
  logic [WORD_W-1:0] word1_q;
  logic [WORD_W-1:0] word2_q;
  logic [1:0] runtime_freq_q;

  // sample words while the core is held, then freeze them
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= LD_IDLE;
      load_cnt_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        LD_IDLE:
        begin
          state_q <= LD_LOAD;
          load_cnt_q <= 4'h0;
        end
        LD_LOAD:
        begin
          load_cnt_q <= load_cnt_q + 4'h1;
          if (load_cnt_q == 4'(LOAD_CYCLES - 1))
            state_q <= LD_DONE;
        end
        LD_DONE: state_q <= LD_DONE;
        default: state_q <= LD_IDLE;
      endcase
    end
  end

  // words are latched only in the load state, so the core never sees a change
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word0_q <= '0;
      word1_q <= '0;
      word2_q <= '0;
    end
    else if (state_q == LD_LOAD)
    begin
      word0_q <= option_config_first;
      word1_q <= option_config_second;
      word2_q <= option_config_third;
    end
  end

  // core reset held until the decoded controls are final when LOAD_CYCLES is 2 or more
  assign core_rst_n = (state_q == LD_DONE);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] hold_len(input logic [1:0] sel);
    case (sel)
      2'h0: hold_len = `HOLD_8;
      2'h1: hold_len = `HOLD_4;
      2'h2: hold_len = `HOLD_16;
      default: hold_len = `HOLD_32;
    endcase
  endfunction : hold_len

  // ----------------------------------------------------------------
  // clock and pin controls
  // ----------------------------------------------------------------
  logic [2:0] clk_mode_sel;
  logic rc_mode;
  logic freq_source_select;
  assign clk_mode_sel = word0_q[`W0_CLK_MODE_HI:`W0_CLK_MODE_LO];
  assign rc_mode = (clk_mode_sel == `RC_MODE_IO) || (clk_mode_sel == `RC_MODE_CLKOUT);
  assign freq_source_select = word1_q[`W1_FREQ_SRC_BIT];

  // registered outputs; reserved modes deselect the rc and clear clk_mode_valid
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_pin_ctrl <= '0;
    else
    begin
      clk_pin_ctrl.clk_mode_valid <= rc_mode;
      clk_pin_ctrl.internal_rc_clock <= rc_mode;
      clk_pin_ctrl.rc_clock_output <= (clk_mode_sel == `RC_MODE_CLKOUT);
      clk_pin_ctrl.second_osc_pin_is_io <= rc_mode;
      if (freq_source_select)
        clk_pin_ctrl.rc_freq <= rc_freq_e'(runtime_freq_q);
      else
        clk_pin_ctrl.rc_freq <= rc_freq_e'(word1_q[`W1_RC_FREQ_HI:`W1_RC_FREQ_LO]);
      clk_pin_ctrl.rc_trim_field <= word1_q[`W1_TRIM_HI:`W1_TRIM_LO];
      clk_pin_ctrl.rc_regulator_enable <= word2_q[`W2_REGULATOR_BIT];
      clk_pin_ctrl.timer_ext_clock_in <= word1_q[`W1_TIMER_IN_BIT];
      clk_pin_ctrl.reset_pin_enable <= word0_q[`W0_RESET_PIN_BIT];
      clk_pin_ctrl.noise_filter_disable <= word0_q[`W0_FILTER_DIS_BIT];
      clk_pin_ctrl.filter_pulse_len <= word0_q[`W0_PULSE_WIDTH_BIT] ?
                                       `PULSE_SHORT : `PULSE_LONG;
    end
  end

  // ----------------------------------------------------------------
  // supervision controls
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sup_ctrl <= '0;
    else
    begin
      sup_ctrl.watchdog_on <= word0_q[`W0_WATCHDOG_BIT];
      // any upper-two-set pattern protects; anything else treated as open
      sup_ctrl.readout_protect <= ((word0_q[`W0_PROTECT_HI:`W0_PROTECT_LO] &
                                    `PROTECT_ON_MASK) == `PROTECT_ON_MASK);
      sup_ctrl.brownout_level <= brownout_e'(word1_q[`W1_BROWNOUT_HI:`W1_BROWNOUT_LO]);
      sup_ctrl.hold_cycles <= hold_len(word2_q[`W2_HOLD_HI:`W2_HOLD_LO]);
      sup_ctrl.sub_osc_freq_sel <= word2_q[`W2_SUB_FREQ_BIT];
      sup_ctrl.sub_osc_trim <= word2_q[`W2_SUB_TRIM_HI:`W2_SUB_TRIM_LO];
      sup_ctrl.transient_immunity_sel <= word2_q[`W2_TRANSIENT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  logic dph_q;
  logic dph_write_q;
  logic [11:0] dph_addr_q;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dph_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q <= 12'h000;
    end
    else if (hready)
    begin
      dph_q <= hsel && htrans[1];
      dph_write_q <= hwrite;
      dph_addr_q <= haddr;
    end
  end

  // runtime frequency register, the only writable word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      runtime_freq_q <= 2'h0;
    else if (dph_q && dph_write_q && dph_addr_q == `OFS_RUNTIME_FREQ)
      runtime_freq_q <= hwdata[`RUNTIME_FREQ_HI:`RUNTIME_FREQ_LO];
  end

  // option words read back only while the core is held in reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr)
        `OFS_FIRST: hrdata <= core_rst_n ? 32'h0 : {19'h0, word0_q};
        `OFS_SECOND: hrdata <= core_rst_n ? 32'h0 : {19'h0, word1_q};
        `OFS_THIRD: hrdata <= core_rst_n ? 32'h0 : {19'h0, word2_q};
        `OFS_STATUS: hrdata <= {29'h0, rc_mode, state_q};
        `OFS_RUNTIME_FREQ: hrdata <= {24'h0, runtime_freq_q, 6'h00};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : option_word_decoder

// ==== core/option_word_defs.svh ====
`ifndef OPTION_WORD_DEFS_SVH
`define OPTION_WORD_DEFS_SVH

// ----------------------------------------------------------------
// register map (private AHB-Lite window, byte addresses)
// ----------------------------------------------------------------
`define OFS_FIRST 12'h000
`define OFS_SECOND 12'h004
`define OFS_THIRD 12'h008
`define OFS_STATUS 12'h00c
`define OFS_RUNTIME_FREQ 12'h010

// ----------------------------------------------------------------
// first option word fields
// ----------------------------------------------------------------
`define W0_PULSE_WIDTH_BIT 11
`define W0_FILTER_DIS_BIT 10
`define W0_RESET_PIN_BIT 9
`define W0_UNUSED_HI 8
`define W0_UNUSED_LO 7
`define W0_WATCHDOG_BIT 6
`define W0_CLK_MODE_HI 5
`define W0_CLK_MODE_LO 3
`define W0_PROTECT_HI 2
`define W0_PROTECT_LO 0

// ----------------------------------------------------------------
// second option word fields
// ----------------------------------------------------------------
`define W1_FREQ_SRC_BIT 12
`define W1_TIMER_IN_BIT 11
`define W1_TRIM_HI 10
`define W1_TRIM_LO 4
`define W1_RC_FREQ_HI 3
`define W1_RC_FREQ_LO 2
`define W1_BROWNOUT_HI 1
`define W1_BROWNOUT_LO 0

// ----------------------------------------------------------------
// third option word fields
// ----------------------------------------------------------------
`define W2_SUB_TRIM_HI 12
`define W2_SUB_TRIM_LO 8
`define W2_TRANSIENT_BIT 7
`define W2_HOLD_HI 6
`define W2_HOLD_LO 5
`define W2_SUB_FREQ_BIT 4
`define W2_REGULATOR_BIT 3

// ----------------------------------------------------------------
// encodings and counts
// ----------------------------------------------------------------
`define RC_MODE_IO 3'h4
`define RC_MODE_CLKOUT 3'h5
`define PROTECT_ON_MASK 3'h6
`define RUNTIME_FREQ_HI 7
`define RUNTIME_FREQ_LO 6
`define PULSE_SHORT 6'h08
`define PULSE_LONG 6'h20
`define HOLD_4 6'h04
`define HOLD_8 6'h08
`define HOLD_16 6'h10
`define HOLD_32 6'h20
`define LOAD_CYCLES 4'h3

`endif

// ==== core/option_word_pkg.sv ====
package option_word_pkg;

  typedef enum logic [1:0] {
    FREQ_4MHZ = 2'h0,
    FREQ_1MHZ = 2'h1,
    FREQ_8MHZ = 2'h2,
    FREQ_455KHZ = 2'h3
  } rc_freq_e;

  typedef enum logic [1:0] {
    BROWNOUT_OFF = 2'h0,
    BROWNOUT_2V5 = 2'h1,
    BROWNOUT_2V9 = 2'h2,
    BROWNOUT_3V2 = 2'h3
  } brownout_e;

  typedef enum logic [1:0] {
    LD_IDLE = 2'h0,
    LD_LOAD = 2'h1,
    LD_DONE = 2'h3
  } load_state_e;

  // clock, pin and filter controls
  typedef struct packed {
    logic clk_mode_valid;
    logic internal_rc_clock;
    logic rc_clock_output;
    logic second_osc_pin_is_io;
    rc_freq_e rc_freq;
    logic [6:0] rc_trim_field;
    logic rc_regulator_enable;
    logic timer_ext_clock_in;
    logic reset_pin_enable;
    logic noise_filter_disable;
    logic [5:0] filter_pulse_len;
  } clk_pin_ctrl_s;

  // supervision and protection controls
  typedef struct packed {
    logic watchdog_on;
    logic readout_protect;
    brownout_e brownout_level;
    logic [5:0] hold_cycles;
    logic sub_osc_freq_sel;
    logic [4:0] sub_osc_trim;
    logic transient_immunity_sel;
  } sup_ctrl_s;

endpackage : option_word_pkg

// ==== test/option_word_checker_assertions.sv ====
`timescale 1ns/1ps
module option_word_checker #(
  parameter int WORD_W = 13,
  parameter int LOAD_CYCLES = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WORD_W-1:0] option_config_first,
  input wire logic [WORD_W-1:0] option_config_second,
  input wire logic [WORD_W-1:0] option_config_third,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic core_rst_n,
  input wire option_word_pkg::clk_pin_ctrl_s clk_pin_ctrl,
  input wire option_word_pkg::sup_ctrl_s sup_ctrl
);
  import option_word_pkg::*;
  // short aliases for the three words
  wire logic [WORD_W-1:0] a = option_config_first;
  wire logic [WORD_W-1:0] b = option_config_second;
  wire logic [WORD_W-1:0] c = option_config_third;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // decoded controls follow the words once the core runs
  // ----------------------------------------------------------------
  chk_clk_mode:
  assert property (core_rst_n |-> clk_pin_ctrl.internal_rc_clock == (a[5:4] == 2'b10)
    && clk_pin_ctrl.rc_clock_output == (a[5:3] == 3'h5)) else $error("clock mode wrong");
  chk_osc_pin_io:
  assert property (clk_pin_ctrl.internal_rc_clock |-> clk_pin_ctrl.second_osc_pin_is_io)
    else $error("second pin not io");
  chk_rc_freq_word:
  assert property (core_rst_n && !b[12] |-> clk_pin_ctrl.rc_freq == b[3:2])
    else $error("rc frequency wrong");
  chk_trim_paths:
  assert property (core_rst_n |-> clk_pin_ctrl.rc_trim_field == b[10:4]
    && sup_ctrl.sub_osc_trim == c[12:8]) else $error("trim wrong");
  chk_pin_select:
  assert property (core_rst_n |-> clk_pin_ctrl.timer_ext_clock_in == b[11]
    && clk_pin_ctrl.reset_pin_enable == a[9]) else $error("pin select wrong");
  chk_filter_setup:
  assert property (core_rst_n |-> clk_pin_ctrl.filter_pulse_len == (a[11] ? 6'h08 : 6'h20)
    && clk_pin_ctrl.noise_filter_disable == a[10]) else $error("filter wrong");
  chk_supervisor:
  assert property (core_rst_n |-> sup_ctrl.watchdog_on == a[6] && sup_ctrl.readout_protect
    == (a[2] & a[1]) && sup_ctrl.brownout_level == b[1:0]) else $error("supervisor wrong");
  chk_hold_count:
  assert property (core_rst_n |-> sup_ctrl.hold_cycles == (c[6:5] == 2'h0 ? 6'h08 :
    c[6:5] == 2'h1 ? 6'h04 : c[6:5] == 2'h2 ? 6'h10 : 6'h20)) else $error("hold wrong");
  chk_sub_osc_reg:
  assert property (core_rst_n |-> sup_ctrl.sub_osc_freq_sel == c[4]
    && clk_pin_ctrl.rc_regulator_enable == c[3]) else $error("sub osc wrong");
  // core reset waits out the whole load
  chk_release_delay:
  assert property ($rose(rst_n) |-> !core_rst_n [*4] ##1 core_rst_n)
    else $error("core reset release wrong");
  chk_word_hidden:
  assert property (core_rst_n && hsel && hready && htrans[1] && !hwrite && haddr < 12'h00c
    |=> hrdata == 32'h0) else $error("option word visible");
  chk_bus_okay:
  assert property (hreadyout && !hresp) else $error("bus response wrong");
  cover property ($rose(core_rst_n));
  cover property (clk_pin_ctrl.rc_clock_output);
  cover property (hsel && htrans[1] && hwrite && haddr == 12'h010);
endmodule : option_word_checker

bind option_word_decoder option_word_checker #(.WORD_W(WORD_W), .LOAD_CYCLES(LOAD_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .option_config_first(option_config_first),
  .option_config_second(option_config_second), .option_config_third(option_config_third),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_rst_n(core_rst_n),
  .clk_pin_ctrl(clk_pin_ctrl), .sup_ctrl(sup_ctrl));

// ==== test/tb_option_word_decoder.sv ====
`timescale 1ns/1ps
module tb_option_word_decoder;
  import option_word_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [12:0] w0 = '0, w1 = '0, w2 = '0;
  logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, core_rst_n;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rd;
  clk_pin_ctrl_s clk_pin_ctrl, cp;
  sup_ctrl_s sup_ctrl, sp;
  logic [5:0] hold_tab [4] = '{6'h08, 6'h04, 6'h10, 6'h20};
  int failures = 0;
  int cmp_count = 0;
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // hsize is fixed at word; the one slave's ready closes the loop
  option_word_decoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .option_config_first(w0),
    .option_config_second(w1), .option_config_third(w2), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_rst_n(core_rst_n),
    .clk_pin_ctrl(clk_pin_ctrl), .sup_ctrl(sup_ctrl));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // one single transfer; waits on ready in both phases
  task automatic bus(logic wr, logic [11:0] addr, logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // words change only under reset, then the load is timed and checked
  task automatic boot(logic [12:0] a, logic [12:0] b, logic [12:0] c);
    int n;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    w0 <= a;
    w1 <= b;
    w2 <= c;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (core_rst_n !== 1'b1 && n < 20);
    cmp("release_edges", 32'h4, 32'(n));
    cp = '0;
    sp = '0;
    cp.internal_rc_clock = (a[5:4] == 2'b10);
    cp.clk_mode_valid = cp.internal_rc_clock;
    cp.rc_clock_output = (a[5:3] == 3'h5);
    cp.second_osc_pin_is_io = cp.internal_rc_clock;
    cp.rc_freq = rc_freq_e'(b[3:2]);
    cp.rc_trim_field = b[10:4];
    cp.rc_regulator_enable = c[3];
    cp.timer_ext_clock_in = b[11];
    cp.reset_pin_enable = a[9];
    cp.noise_filter_disable = a[10];
    cp.filter_pulse_len = a[11] ? 6'h08 : 6'h20;
    sp.watchdog_on = a[6];
    sp.readout_protect = a[2] & a[1];
    sp.brownout_level = brownout_e'(b[1:0]);
    sp.hold_cycles = hold_tab[c[6:5]];
    sp.sub_osc_freq_sel = c[4];
    sp.sub_osc_trim = c[12:8];
    sp.transient_immunity_sel = c[7];
    if (!b[12])
      cmp("clk_pin_ctrl", 32'(cp), 32'(clk_pin_ctrl));
    cmp("sup_ctrl", 32'(sp), 32'(sup_ctrl));
  endtask : boot
  // ----------------------------------------------------------------
  // test sequence; unused word bits stay zero throughout
  // ----------------------------------------------------------------
  initial
  begin
    boot(13'h0020, 13'h0000, 13'h0000);
    boot(13'h0e6e, 13'h0d55, 13'h15b8);
    boot(13'h0001, 13'h000a, 13'h0040);
    boot(13'h0037, 13'h02af, 13'h0a60);
    boot(13'h0028, 13'h1000, 13'h0000);
    bus(1'b1, 12'h010, 32'h00000080);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp("rc_freq_runtime", 32'h2, 32'(clk_pin_ctrl.rc_freq));
    bus(1'b0, 12'h010, 32'h0);
    cmp("runtime_reg", 32'h00000080, rd);
    bus(1'b1, 12'h004, 32'hffffffff);
    bus(1'b0, 12'h004, 32'h0);
    cmp("word_read", 32'h0, rd);
    bus(1'b0, 12'h020, 32'h0);
    cmp("unmapped_read", 32'h0, rd);
    bus(1'b0, 12'h00c, 32'h0);
    cmp("status_read", 32'h00000007, rd);
    end_sim();
  end
  // watchdog against a hung handshake
  initial
  begin
    #20000;
    failures++;
    end_sim();
  end
endmodule : tb_option_word_decoder
